//--- design/stepper_microstep_indexer.sv
// Two-pair stepping motor indexer with microstep table, chopper and AXI4-Lite registers
// Contract
// - Clear low resets position, state, and floats all bridge outputs.
// - Control inputs are only accepted while clear is high.
// - Micro or half mode leaves clear with A at 100%, B at 0%.
// - Full-step mode leaves clear with both phases at +100%.
// - Full-step mode drives both phases at plus or minus 100% together.
// - Half mode diagonal positions use equal-torque reduced currents.
// - Four select inputs choose full, half or micro operation.
// - Select inputs choose saturated or chopped current-regulated drive; micro mode here is always chopped.
// - Micro mode splits one electrical period into 64 steps.
// - First-quadrant table follows the published percent values; B reversed.
// - Step 0 is the position right after clear release.
// - Step index drives DAC level combined with chopping period.
// - Gate low floats both bridges of that pair.
// - Gate low keeps step position for later resumption.
// - Micro mode flag low when either phase magnitude is 100%.
// - Coarse modes flag low only at index 8, both phases positive (100% in full, 70.7% in half).
// - Each rising step edge advances position by exactly one step.
// - Clockwise: phase B lags phase A by 90 degrees.
// - Counter-clockwise: phase B leads phase A by 90 degrees.
// - Micro to coarse change: hold, then jump to next coarse position.
`timescale 1ns/10ps
`include "stepper_indexer_params.svh"

module stepper_microstep_indexer
  import stepper_indexer_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int MAG_W  = 10
) (
  input  wire logic                 I_CLK,
  input  wire logic                 I_RST_N,
  input  wire logic                 I_ACTIVE_LOW_CLEAR_N,
  input  wire logic                 I_STEP_PULSE_PAIR1,
  input  wire logic                 I_STEP_PULSE_PAIR2,
  input  wire logic                 I_DIRECTION_PAIR1,
  input  wire logic                 I_DIRECTION_PAIR2,
  input  wire logic                 I_OUTPUT_GATE_PAIR1,
  input  wire logic                 I_OUTPUT_GATE_PAIR2,
  input  wire logic                 I_EXCITATION_SELECT_1,
  input  wire logic                 I_EXCITATION_SELECT_2,
  input  wire logic                 I_EXCITATION_SELECT_3,
  input  wire logic                 I_EXCITATION_SELECT_4,
  input  wire logic [3:0]           I_SENSE_TRIP,
  input  wire logic [ADDR_W-1:0]    I_AWADDR,
  input  wire logic                 I_AWVALID,
  output logic                      O_AWREADY,
  input  wire logic [31:0]          I_WDATA,
  input  wire logic [3:0]           I_WSTRB,
  input  wire logic                 I_WVALID,
  output logic                      O_WREADY,
  output logic [1:0]                O_BRESP,
  output logic                      O_BVALID,
  input  wire logic                 I_BREADY,
  input  wire logic [ADDR_W-1:0]    I_ARADDR,
  input  wire logic                 I_ARVALID,
  output logic                      O_ARREADY,
  output logic [31:0]               O_RDATA,
  output logic [1:0]                O_RRESP,
  output logic                      O_RVALID,
  input  wire logic                 I_RREADY,
  output logic [3:0]                O_BRIDGE_A,
  output logic [3:0]                O_BRIDGE_B,
  output logic [3:0]                O_BRIDGE_OE,
  output logic [4*MAG_W-1:0]        O_DAC_LEVEL,
  output logic                      O_POSITION_FLAG_PAIR1,
  output logic                      O_POSITION_FLAG_PAIR1_OE,
  output logic                      O_POSITION_FLAG_PAIR2,
  output logic                      O_POSITION_FLAG_PAIR2_OE
);

  // First-quadrant magnitude, tenths of a percent
  function automatic logic [MAG_W-1:0] tbl(input logic [4:0] r);
    unique case (r)
      5'h00, 5'h01: tbl = 10'h3E8;
      5'h02: tbl = 10'h3D5;
      5'h03: tbl = 10'h3BD;
      5'h04: tbl = 10'h39C;
      5'h05: tbl = 10'h372;
      5'h06: tbl = 10'h33F;
      5'h07: tbl = 10'h305;
      5'h08: tbl = 10'h2C3;
      5'h09: tbl = 10'h27A;
      5'h0A: tbl = 10'h22C;
      5'h0B: tbl = 10'h1D7;
      5'h0C: tbl = 10'h17F;
      5'h0D: tbl = 10'h122;
      5'h0E: tbl = 10'h0C3;
      5'h0F: tbl = 10'h062;
      default: tbl = 10'h000;
    endcase
  endfunction : tbl

  function automatic mode_t decode_mode(input logic [3:0] s, input logic p);
    mode_t coarse;
    coarse = s[0] ? MD_HALF : MD_FULL;
    unique case (s[3:1])
      3'h0: decode_mode = p ? MD_OFF : MD_FULL;
      3'h1: decode_mode = p ? MD_OFF : MD_HALF;
      3'h2: decode_mode = p ? MD_OFF : MD_MICRO;
      3'h3, 3'h4: decode_mode = coarse;
      3'h5: decode_mode = p ? MD_MICRO : coarse;
      3'h6: decode_mode = p ? coarse : MD_MICRO;
      3'h7: decode_mode = s[0] ? MD_SAVE : MD_MICRO;
    endcase
  endfunction : decode_mode

  // Mirror the quadrant table; B is A shifted a quarter period
  function automatic logic [MAG_W-1:0] phase_mag(input logic [5:0] ix, input logic b,
                                                 input mode_t m);
    logic [4:0] r;
    r = {1'b0, ix[3:0]};
    if (m == MD_FULL) phase_mag = `FULL_PCT;
    else phase_mag = (ix[4] ^ b) ? tbl(5'h10 - r) : tbl(r);
  endfunction : phase_mag

  function automatic logic phase_neg(input logic [5:0] ix, input logic b);
    phase_neg = b ? ix[5] : (ix[5] ^ ix[4]);
  endfunction : phase_neg

  // Coarse modes land on their own grid from any micro position
  function automatic logic [5:0] next_idx(input logic [5:0] ix, input logic ccw,
                                          input mode_t m);
    unique case (m)
      MD_FULL: next_idx = ccw ? ((ix - 6'h09) & 6'h30) + 6'h08 : ((ix + 6'h08) & 6'h30) + 6'h08;
      MD_HALF: next_idx = ccw ? ((ix - 6'h01) & 6'h38) : ((ix + 6'h08) & 6'h38);
      default: next_idx = ccw ? ix - 6'h01 : ix + 6'h01;
    endcase
  endfunction : next_idx

  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  wire logic       clr = I_ACTIVE_LOW_CLEAR_N;
  wire logic [3:0] sel = {I_EXCITATION_SELECT_1, I_EXCITATION_SELECT_2,
                          I_EXCITATION_SELECT_3, I_EXCITATION_SELECT_4};
  wire logic [1:0] step_in = {I_STEP_PULSE_PAIR2, I_STEP_PULSE_PAIR1};
  wire logic [1:0] dir_in  = {I_DIRECTION_PAIR2, I_DIRECTION_PAIR1};
  wire logic [1:0] gate_in = {I_OUTPUT_GATE_PAIR2, I_OUTPUT_GATE_PAIR1};
  wire logic       sat     = sel[3:1] != 3'h4;

  logic [1:0]       s1_reg, s2_reg, s3_reg;
  logic [5:0]       idx_reg [2];
  logic [5:0]       idx_next [2];
  mode_t            mode [2];
  logic [1:0]       run, active, step_ok, flag_low;
  logic [1:0]       flag_oe_reg;
  logic [MAG_W-1:0] mag [4];
  logic [MAG_W-1:0] dac_reg [4];
  logic [3:0]       neg, on_next, on_reg, a_reg, b_reg;
  logic [15:0]      chop_reg, chop_next, cnt_reg;
  wire logic        chop_start = cnt_reg == 16'h0000;

  // Two stages before the edge detector; it compares the second stage with the third
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
      s3_reg <= 2'h0;
    end else begin
      s1_reg <= step_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N || cnt_reg >= chop_reg) cnt_reg <= 16'h0000;
    else cnt_reg <= cnt_reg + 16'h0001;
  end

  genvar p, b;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      assign mode[p]     = decode_mode(sel, 1'(p));
      assign run[p]      = mode[p] inside {MD_FULL, MD_HALF, MD_MICRO};
      assign active[p]   = clr && gate_in[p] && run[p];
      // Gated pair ignores steps so position is preserved
      assign step_ok[p]  = s2_reg[p] && !s3_reg[p] && active[p];
      assign idx_next[p] = next_idx(idx_reg[p], dir_in[p], mode[p]);
      assign flag_low[p] = (mode[p] == MD_MICRO) ?
                           (mag[2*p] == `FULL_PCT || mag[2*p+1] == `FULL_PCT) :
                           (idx_reg[p] == `START_FULL);

      always_ff @(posedge I_CLK) begin
        if (!I_RST_N) idx_reg[p] <= `START_OTHER;
        else if (!clr) idx_reg[p] <= (mode[p] == MD_FULL) ? `START_FULL : `START_OTHER;
        else if (step_ok[p]) idx_reg[p] <= idx_next[p];
      end

      always_ff @(posedge I_CLK) begin
        if (!I_RST_N) flag_oe_reg[p] <= 1'b0;
        else flag_oe_reg[p] <= active[p] && flag_low[p];
      end

      clear_start_a: assert property ((!clr && mode[p] == MD_FULL) |=>
        (clr |-> mag[2*p] == `FULL_PCT && mag[2*p+1] == `FULL_PCT && !neg[2*p] && !neg[2*p+1]))
        else $error("full mode does not start at +100 on both phases");
      clear_micro_a: assert property ((!clr && mode[p] == MD_MICRO) ##1 (clr && mode[p] == MD_MICRO)
        |-> mag[2*p] == `FULL_PCT && mag[2*p+1] == 10'h000)
        else $error("micro mode does not start at A 100, B 0");
      step_one_a: assert property ((step_ok[p] && mode[p] == MD_MICRO) |=>
        idx_reg[p] == $past(idx_reg[p]) + ($past(dir_in[p]) ? 6'h3F : 6'h01))
        else $error("micro step did not move exactly one position");
      gate_hold_a: assert property ((clr && !gate_in[p]) [*3] |->
        idx_reg[p] == $past(idx_reg[p], 2))
        else $error("position moved while outputs gated");
      gate_hiz_a: assert property (!gate_in[p] |=>
        O_BRIDGE_OE[2*p+1 -: 2] == 2'h0 && !flag_oe_reg[p])
        else $error("gated pair still drives");
      coarse_jump_a: assert property ((step_ok[p] && mode[p] == MD_FULL) |=>
        idx_reg[p][3:0] == 4'h8 && idx_reg[p] != $past(idx_reg[p]))
        else $error("full step not on next diagonal");
      flag_micro_a: assert property ((active[p] && mode[p] == MD_MICRO &&
        (mag[2*p] == `FULL_PCT || mag[2*p+1] == `FULL_PCT)) |=> flag_oe_reg[p])
        else $error("position flag not asserted at full phase");
      full_mag_a: assert property ((mode[p] == MD_FULL && active[p]) |=>
        O_DAC_LEVEL[2*p*MAG_W +: 2*MAG_W] == {`FULL_PCT, `FULL_PCT})
        else $error("full mode magnitude below 100");
      cov_micro_wrap: cover property (step_ok[p] && idx_reg[p] == 6'h3F && !dir_in[p]);
      cov_gate_resume: cover property (!gate_in[p] ##1 gate_in[p] && step_ok[p]);
      cov_micro_to_full: cover property (mode[p] == MD_MICRO ##1 mode[p] == MD_FULL && step_ok[p]);
    end

    for (b = 0; b < 4; b++) begin : g_bridge
      localparam int   P  = b / 2;
      localparam logic PH = 1'(b % 2);
      assign mag[b] = phase_mag(idx_reg[P], PH, mode[P]);
      assign neg[b] = phase_neg(idx_reg[P], PH);
      // Regulated drive: on at chop start, off on sense trip until next period
      assign on_next[b] = !active[P] || mag[b] == 10'h000 ? 1'b0 :
                          (sat && mode[P] != MD_MICRO) ? 1'b1 :
                          chop_start ? 1'b1 :
                          I_SENSE_TRIP[b] ? 1'b0 : on_reg[b];

      always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
          on_reg[b]  <= 1'b0;
          a_reg[b]   <= 1'b0;
          b_reg[b]   <= 1'b0;
          dac_reg[b] <= 10'h000;
        end else begin
          on_reg[b]  <= on_next[b];
          a_reg[b]   <= !neg[b];
          b_reg[b]   <= neg[b];
          dac_reg[b] <= active[P] ? mag[b] : 10'h000;
        end
      end
      assign O_DAC_LEVEL[b*MAG_W +: MAG_W] = dac_reg[b];
    end
  endgenerate

  clear_hiz_a: assert property (!clr |=> O_BRIDGE_OE == 4'h0 && flag_oe_reg == 2'h0)
    else $error("outputs driven during clear");
  chop_trip_a: assert property ((clr && gate_in[0] && mode[0] == MD_MICRO &&
    mag[0] != 10'h000 && chop_start) |=> O_BRIDGE_OE[0])
    else $error("chopper did not switch on at period start");

  assign O_BRIDGE_OE = on_reg;
  assign O_BRIDGE_A  = a_reg;
  assign O_BRIDGE_B  = b_reg;
  assign O_POSITION_FLAG_PAIR1    = 1'b0;
  assign O_POSITION_FLAG_PAIR2    = 1'b0;
  assign O_POSITION_FLAG_PAIR1_OE = flag_oe_reg[0];
  assign O_POSITION_FLAG_PAIR2_OE = flag_oe_reg[1];

  // AXI4-Lite slave; address and data may arrive in either order
  logic              aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg, rdata_reg;
  logic [3:0]        wstrb_reg;
  logic [1:0]        bresp_reg, rresp_reg;

  assign O_AWREADY = !aw_got_reg && !bvalid_reg;
  assign O_WREADY  = !w_got_reg && !bvalid_reg;
  assign O_ARREADY = !rvalid_reg;
  assign O_BVALID  = bvalid_reg;
  assign O_BRESP   = bresp_reg;
  assign O_RVALID  = rvalid_reg;
  assign O_RDATA   = rdata_reg;
  assign O_RRESP   = rresp_reg;

  wire logic              aw_hs  = I_AWVALID && O_AWREADY;
  wire logic              w_hs   = I_WVALID && O_WREADY;
  wire logic              ar_hs  = I_ARVALID && O_ARREADY;
  wire logic              wr_go  = (aw_got_reg || aw_hs) && (w_got_reg || w_hs);
  wire logic [ADDR_W-1:0] wa     = aw_got_reg ? awaddr_reg : I_AWADDR;
  wire logic [31:0]       wd     = w_got_reg ? wdata_reg : I_WDATA;
  wire logic [3:0]        ws     = w_got_reg ? wstrb_reg : I_WSTRB;
  wire logic              wa_ok  = wa == `CHOP_REG_OFF || wa == `STAT1_REG_OFF ||
                                   wa == `STAT2_REG_OFF;
  wire logic [31:0]       stat1  = (32'(idx_reg[0]) << `STAT_IDX_LSB) |
                                   (32'(mode[0]) << `STAT_MODE_LSB) |
                                   (32'(flag_low[0]) << `STAT_FLAG_BIT) |
                                   (32'(active[0]) << `STAT_ACT_BIT);
  wire logic [31:0]       stat2  = (32'(idx_reg[1]) << `STAT_IDX_LSB) |
                                   (32'(mode[1]) << `STAT_MODE_LSB) |
                                   (32'(flag_low[1]) << `STAT_FLAG_BIT) |
                                   (32'(active[1]) << `STAT_ACT_BIT);
  wire logic              ra_ok  = I_ARADDR == `CHOP_REG_OFF || I_ARADDR == `STAT1_REG_OFF ||
                                   I_ARADDR == `STAT2_REG_OFF;
  wire logic [31:0]       rd_mux = I_ARADDR == `CHOP_REG_OFF  ? {16'h0000, chop_reg} :
                                   I_ARADDR == `STAT1_REG_OFF ? stat1 :
                                   I_ARADDR == `STAT2_REG_OFF ? stat2 : 32'h0000_0000;

  assign chop_next = {ws[1] ? wd[15:8] : chop_reg[15:8], ws[0] ? wd[7:0] : chop_reg[7:0]};

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else begin
      if (aw_hs) awaddr_reg <= I_AWADDR;
      if (w_hs) wdata_reg <= I_WDATA;
      if (w_hs) wstrb_reg <= I_WSTRB;
      aw_got_reg <= (aw_got_reg || aw_hs) && !wr_go;
      w_got_reg  <= (w_got_reg || w_hs) && !wr_go;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      chop_reg   <= 16'(`CHOP_CYC);
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (wr_go) begin
      if (wa == `CHOP_REG_OFF) chop_reg <= chop_next;
      bvalid_reg <= 1'b1;
      bresp_reg  <= wa_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (I_BREADY) bvalid_reg <= 1'b0;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= ra_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (I_RREADY) rvalid_reg <= 1'b0;
  end

  axi_write_resp_a: assert property (wr_go |=> O_BVALID && !O_AWREADY && !O_WREADY)
    else $error("write response not raised after address and data");
  cov_axi_write: cover property (wr_go && aw_hs && w_hs);

endmodule : stepper_microstep_indexer

//--- design/stepper_indexer_params.svh
// Offsets, field positions, reset values and timing counts of the step indexer
`ifndef STEPPER_INDEXER_PARAMS_SVH
`define STEPPER_INDEXER_PARAMS_SVH
`define CHOP_REG_OFF   8'h00
`define STAT1_REG_OFF  8'h04
`define STAT2_REG_OFF  8'h08
`define STAT_IDX_LSB   0
`define STAT_MODE_LSB  8
`define STAT_FLAG_BIT  16
`define STAT_ACT_BIT   17
`define CLK_MHZ        250
`define CHOP_NS        400
`define CHOP_CYC       (`CHOP_NS * `CLK_MHZ / 1000)
`define FULL_PCT       10'h3E8
`define START_FULL     6'h08
`define START_OTHER    6'h00
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

//--- design/stepper_indexer_pkg.sv
// Types shared by the step indexer
package stepper_indexer_pkg;
  typedef enum logic [4:0] {
    MD_OFF   = 5'h01,
    MD_FULL  = 5'h02,
    MD_HALF  = 5'h04,
    MD_MICRO = 5'h08,
    MD_SAVE  = 5'h10
  } mode_t;
endpackage : stepper_indexer_pkg

//--- sim/host_stepper_model.sv
// Host model that issues step pulses and a direction level for one motor pair
`timescale 1ns/10ps
module host_stepper_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_req,
  input  wire logic i_dir,
  input  wire logic i_slow,
  output logic      o_step,
  output logic      o_dir,
  output logic      o_busy
);
  logic [3:0] cnt_reg;
  logic [3:0] half_reg;
  logic [3:0] len;

  // Slow pulses stretch both levels; each level lasts at least four cycles
  assign len = i_slow ? 4'h6 : 4'h4;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_step   <= 1'b0;
      o_dir    <= 1'b0;
      o_busy   <= 1'b0;
      cnt_reg  <= 4'h0;
      half_reg <= 4'h0;
    end else if (!o_busy && i_req) begin
      o_busy   <= 1'b1;
      o_step   <= 1'b1;
      o_dir    <= i_dir;
      half_reg <= len;
      cnt_reg  <= {len[2:0], 1'b0} - 4'h1;
    end else if (o_busy) begin
      o_busy  <= (cnt_reg != 4'h0);
      cnt_reg <= cnt_reg - 4'h1;
      o_step  <= (cnt_reg > half_reg);
    end
  end
endmodule : host_stepper_model

//--- sim/stepper_microstep_indexer_tb_top.sv
// Self-checking bench for the step indexer
`timescale 1ns/10ps
`include "stepper_indexer_params.svh"
module stepper_microstep_indexer_tb_top;
  logic        clk = 1'b0;
  logic        rst_n, clr_n, g1, g2, req1, req2, dir1, dir2, slow, dr;
  logic [3:0]  sel, trip, wstrb;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rd;
  logic [1:0]  rs;
  logic [9:0]  m;
  wire         awready, wready, bvalid, arready, rvalid, f1, f1_oe, f2, f2_oe;
  wire         st1, st2, d1, d2, bz1, bz2;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [3:0]  br_a, br_b, br_oe;
  wire  [39:0] dac;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          seed = 32'h245C17DE;
  int          idx;
  localparam logic [9:0] CTAB [0:16] = '{10'h3E8, 10'h3E8, 10'h3D5, 10'h3BD, 10'h39C,
    10'h372, 10'h33F, 10'h305, 10'h2C3, 10'h27A, 10'h22C, 10'h1D7, 10'h17F, 10'h122,
    10'h0C3, 10'h062, 10'h000};

  always #2 clk = ~clk;

  stepper_microstep_indexer stepper_microstep_indexer_inst (
    .I_CLK(clk), .I_RST_N(rst_n), .I_ACTIVE_LOW_CLEAR_N(clr_n),
    .I_STEP_PULSE_PAIR1(st1), .I_STEP_PULSE_PAIR2(st2),
    .I_DIRECTION_PAIR1(d1), .I_DIRECTION_PAIR2(d2),
    .I_OUTPUT_GATE_PAIR1(g1), .I_OUTPUT_GATE_PAIR2(g2),
    .I_EXCITATION_SELECT_1(sel[3]), .I_EXCITATION_SELECT_2(sel[2]),
    .I_EXCITATION_SELECT_3(sel[1]), .I_EXCITATION_SELECT_4(sel[0]), .I_SENSE_TRIP(trip),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_BRIDGE_A(br_a), .O_BRIDGE_B(br_b), .O_BRIDGE_OE(br_oe),
    .O_DAC_LEVEL(dac), .O_POSITION_FLAG_PAIR1(f1), .O_POSITION_FLAG_PAIR1_OE(f1_oe),
    .O_POSITION_FLAG_PAIR2(f2), .O_POSITION_FLAG_PAIR2_OE(f2_oe));
  host_stepper_model host_p1 (.i_clk(clk), .i_rst_n(rst_n), .i_req(req1), .i_dir(dir1),
    .i_slow(slow), .o_step(st1), .o_dir(d1), .o_busy(bz1));
  host_stepper_model host_p2 (.i_clk(clk), .i_rst_n(rst_n), .i_req(req2), .i_dir(dir2),
    .i_slow(slow), .o_step(st2), .o_dir(d2), .o_busy(bz2));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task test_done;
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi_rd

  // Magnitude of cosine (b=0) or sine (b=1) mirrored from the first quadrant
  function automatic logic [9:0] mag_of(input int i, input bit b);
    return CTAB[(((i / 16) % 2) ^ b) ? 16 - (i % 16) : i % 16];
  endfunction : mag_of

  function automatic logic pos_of(input int i, input bit b);
    return b ? (i < 32) : (i < 16 || i >= 48);
  endfunction : pos_of

  function automatic logic [9:0] mode_exp(input logic [3:0] s);
    logic [4:0] c;
    c = s[0] ? 5'h04 : 5'h02;
    case (s[3:1])
      3'h0: return {5'h02, 5'h01};
      3'h1: return {5'h04, 5'h01};
      3'h2: return {5'h08, 5'h01};
      3'h3, 3'h4: return {c, c};
      3'h5: return {c, 5'h08};
      3'h6: return {5'h08, c};
      default: return s[0] ? {5'h10, 5'h10} : {5'h08, 5'h08};
    endcase
  endfunction : mode_exp

  task automatic end_test(input string t);
    $display("Test %s done", t);
  endtask : end_test

  task automatic do_step(input int p, input logic d);
    req1 <= (p == 1);
    req2 <= (p == 2);
    dir1 <= d;
    dir2 <= d;
    slow <= 1'($random(seed));
    @(posedge clk);
    req1 <= 1'b0;
    req2 <= 1'b0;
    do @(posedge clk); while (bz1 || bz2);
    tick(2);
  endtask : do_step

  task automatic chk_out(input bit full, input bit micro);
    logic [9:0] ma, mb;
    ma = full ? `FULL_PCT : mag_of(idx, 0);
    mb = full ? `FULL_PCT : mag_of(idx, 1);
    check("dac_a", 32'(dac[9:0]), 32'(ma));
    check("dac_b", 32'(dac[19:10]), 32'(mb));
    check("flag_oe", 32'(f1_oe), micro ? 32'(ma == `FULL_PCT || mb == `FULL_PCT)
          : 32'(idx == 8));
    if (ma != 10'h000) check("pol_a", 32'(br_a[0]), 32'(pos_of(idx, 0)));
    if (mb != 10'h000) check("pol_b", 32'(br_a[1]), 32'(pos_of(idx, 1)));
    if (ma != 10'h000) check("neg_a", 32'(br_b[0]), 32'(!pos_of(idx, 0)));
    if (mb != 10'h000) check("neg_b", 32'(br_b[1]), 32'(!pos_of(idx, 1)));
    check("flag_level", 32'({f1, f2}), 32'h0);
    axi_rd(`STAT1_REG_OFF);
    check("index", 32'(rd[5:0]), 32'(idx));
  endtask : chk_out

  task automatic clr;
    clr_n <= 1'b0;
    tick(3);
    check("oe_clear", 32'(br_oe), 32'h0);
    check("flag_clear", 32'({f1_oe, f2_oe}), 32'h0);
    clr_n <= 1'b1;
    tick(4);
  endtask : clr

  // Watchdog well above the fewer than one thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    {rst_n, clr_n, g1, g2, req1, req2, dir1, dir2, slow} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {sel, trip, wstrb, awaddr, araddr, wdata} = '0;
    tick(6);
    rst_n <= 1'b1;
    tick(1);
    axi_rd(8'h00);
    check("chop_rst", rd, 32'h00000064);
    axi_wr(8'h00, 32'hFFFF0004);
    axi_rd(8'h00);
    check("chop", rd, 32'h00000004);
    axi_wr(8'h0C, 32'h00000001);
    check("wr_unmapped", 32'(rs), 32'(`RESP_SLVERR));
    axi_rd(8'h0C);
    check("rd_unmapped", {rd[29:0], rs}, 32'(`RESP_SLVERR));
    axi_wr(`STAT1_REG_OFF, 32'hFFFFFFFF);
    check("wr_status", 32'(rs), 32'(`RESP_OKAY));
    end_test("registers");
    for (int s = 0; s < 16; s++) begin
      sel <= 4'(s);
      m = mode_exp(4'(s));
      tick(3);
      axi_rd(`STAT1_REG_OFF);
      check("excitation_select_1", 32'(rd[12:8]), 32'(m[9:5]));
      axi_rd(`STAT2_REG_OFF);
      check("excitation_select_2", 32'(rd[12:8]), 32'(m[4:0]));
    end
    end_test("modes");
    sel <= 4'hE;
    g1 <= 1'b1;
    g2 <= 1'b1;
    clr();
    idx = 0;
    chk_out(0, 1);
    do_step(1, 1'b1);
    idx = 63;
    chk_out(0, 1);
    repeat (24) begin
      dr = 1'($random(seed));
      do_step(1, dr);
      idx = (idx + (dr ? 63 : 1)) % 64;
      chk_out(0, 1);
    end
    repeat (3) do_step(2, 1'b1);
    check("dac_p2", 32'(dac[29:20]), 32'(mag_of(61, 0)));
    axi_rd(`STAT2_REG_OFF);
    check("index_p2", 32'(rd[5:0]), 32'd61);
    end_test("micro");
    clr();
    idx = 0;
    wait_oe(0, 1'b1, 12);
    trip <= 4'h1;
    wait_oe(0, 1'b0, 4);
    trip <= 4'h0;
    wait_oe(0, 1'b1, 12);
    end_test("chop");
    g1 <= 1'b0;
    tick(3);
    check("oe_gated", 32'(br_oe[1:0]), 32'h0);
    check("flag_gated", 32'(f1_oe), 32'h0);
    do_step(1, 1'b0);
    g1 <= 1'b1;
    tick(4);
    chk_out(0, 1);
    repeat (3) do_step(1, 1'b0);
    idx = 3;
    sel <= 4'h6;
    tick(4);
    axi_rd(`STAT1_REG_OFF);
    check("index_hold", 32'(rd[5:0]), 32'd3);
    do_step(1, 1'b0);
    idx = 8;
    chk_out(1, 0);
    do_step(1, 1'b0);
    idx = 24;
    chk_out(1, 0);
    trip <= 4'h1;
    tick(8);
    check("oe_saturated", 32'(br_oe[0]), 32'h1);
    trip <= 4'h0;
    clr();
    idx = 8;
    chk_out(1, 0);
    end_test("full");
    sel <= 4'h2;
    tick(4);
    chk_out(0, 0);
    do_step(1, 1'b0);
    idx = 16;
    chk_out(0, 0);
    do_step(1, 1'b1);
    idx = 8;
    chk_out(0, 0);
    end_test("half");
    test_done();
  end

  task automatic wait_oe(input int b, input logic v, input int lim);
    int k;
    k = 0;
    while (br_oe[b] !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    check("bridge_oe", 32'(br_oe[b]), 32'(v));
  endtask : wait_oe
endmodule : stepper_microstep_indexer_tb_top
